// ---- design/sleep_pkg.sv ----
package sleep_pkg;

  // Low-power mode encodings selected by the core before it sleeps.
  typedef enum logic [2:0] {
    MODE_IDLE,
    MODE_POWER_DOWN,
    MODE_POWER_SAVE,
    MODE_STANDBY,
    MODE_EXT_STANDBY
  } sleep_mode_t;

  // Controller states.
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_DRAIN,
    ST_SLEEP,
    ST_WAKE
  } ctrl_state_t;

  // Number of peripheral clock branches and interrupt lines.
  localparam int unsigned PERIPH_COUNT = 8;
  localparam int unsigned IRQ_COUNT = 8;

  // Interrupt line positions of the three power-down wake sources.
  localparam int unsigned IRQ_TWI_ADDR = 0;
  localparam int unsigned IRQ_PORT_ASYNC = 1;
  localparam int unsigned IRQ_USB_RESUME = 2;

  // Wake source masks per mode; power-save and standby sets are free choices.
  localparam logic [7:0] WAKE_ALL = 8'hff;
  localparam logic [7:0] WAKE_POWER_DOWN = 8'h07;
  localparam logic [7:0] WAKE_POWER_SAVE = 8'h0f;
  localparam logic [7:0] WAKE_STANDBY = 8'h0f;
  localparam logic [7:0] WAKE_EXT_STANDBY = 8'h0f;

  // Whether the real-time counter clock keeps running in each deep mode.
  localparam logic RTC_RUN_POWER_SAVE = 1'b1;
  localparam logic RTC_RUN_STANDBY = 1'b0;
  localparam logic RTC_RUN_EXT_STANDBY = 1'b1;

  // Stall after wake-up, in cycles.
  localparam int unsigned WAKE_STALL_CYCLES = 4;
  localparam logic [2:0] WAKE_STALL_LAST = 3'h3;
  localparam logic [2:0] STALL_ZERO = 3'h0;
  localparam logic [2:0] STALL_ONE = 3'h1;

endpackage

// ---- design/sleep_mode_controller.sv ----
`timescale 1ns/1ps
`default_nettype none

module sleep_mode_controller
(
  // Clock and synchronous reset.
  input wire logic clk,
  input wire logic rst,
  // Core side.
  input wire logic sleep_enable,
  input wire sleep_pkg::sleep_mode_t sleep_mode,
  input wire logic sleep_exec,
  output logic core_run,
  output logic wake_pulse,
  // Interrupt controller side.
  input wire logic [7:0] irq_pending,
  input wire logic [7:0] irq_enabled,
  output logic [7:0] wake_sources,
  output logic irq_dispatch_en,
  // Non-volatile memory.
  input wire logic nvm_busy,
  output logic nvm_clk_en,
  // Clock enables.
  input wire logic [7:0] periph_gate,
  output logic [7:0] periph_clk_en,
  output logic periph_bus_clk_en,
  output logic rtc_clk_en,
  output logic asleep
);

  sleep_pkg::ctrl_state_t state_q;
  sleep_pkg::ctrl_state_t state_d;
  sleep_pkg::sleep_mode_t mode_q;
  logic [2:0] stall_q;
  logic [7:0] wake_mask;
  logic wake_hit;
  logic sleep_next;
  logic deep_next;

  // Returns the wake source mask for a mode.
  function automatic logic [7:0] wake_mask_of(input sleep_pkg::sleep_mode_t m);
    unique case (m)
      sleep_pkg::MODE_IDLE: wake_mask_of = sleep_pkg::WAKE_ALL;
      sleep_pkg::MODE_POWER_DOWN: wake_mask_of = sleep_pkg::WAKE_POWER_DOWN;
      sleep_pkg::MODE_POWER_SAVE: wake_mask_of = sleep_pkg::WAKE_POWER_SAVE;
      sleep_pkg::MODE_STANDBY: wake_mask_of = sleep_pkg::WAKE_STANDBY;
      sleep_pkg::MODE_EXT_STANDBY: wake_mask_of = sleep_pkg::WAKE_EXT_STANDBY;
      default: wake_mask_of = sleep_pkg::WAKE_ALL;
    endcase
  endfunction

  // Accepts a sleep instruction only while the core runs and sleep is enabled.
  function automatic logic sleep_taken(input sleep_pkg::ctrl_state_t s, input logic exec,
                                       input logic enable);
    sleep_taken = (s == sleep_pkg::ST_ACTIVE) && exec && enable;
  endfunction

  // Last count of the wake stall; the core restarts on the following edge.
  function automatic logic stall_at_end(input logic [2:0] count);
    stall_at_end = (count == sleep_pkg::WAKE_STALL_LAST);
  endfunction

  // Real-time counter clock choice in the deep modes; power-down stops it too.
  function automatic logic rtc_run_of(input sleep_pkg::sleep_mode_t m);
    unique case (m)
      sleep_pkg::MODE_POWER_SAVE: rtc_run_of = sleep_pkg::RTC_RUN_POWER_SAVE;
      sleep_pkg::MODE_STANDBY: rtc_run_of = sleep_pkg::RTC_RUN_STANDBY;
      sleep_pkg::MODE_EXT_STANDBY: rtc_run_of = sleep_pkg::RTC_RUN_EXT_STANDBY;
      default: rtc_run_of = 1'b0;
    endcase
  endfunction

  // Wake decision uses the mode latched when sleep began.
  always_comb
  begin
    wake_mask = wake_mask_of(mode_q);
    wake_hit = |(irq_pending & irq_enabled & wake_mask);
  end

  // Next-state logic of the sleep sequence.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      sleep_pkg::ST_ACTIVE:
      begin
        if (sleep_taken(state_q, sleep_exec, sleep_enable))
        begin
          state_d = sleep_pkg::ST_DRAIN;
        end
      end
      sleep_pkg::ST_DRAIN:
      begin
        if (wake_hit)
        begin
          state_d = sleep_pkg::ST_WAKE;
        end
        else if (!nvm_busy)
        begin
          state_d = sleep_pkg::ST_SLEEP;
        end
      end
      sleep_pkg::ST_SLEEP:
      begin
        if (wake_hit)
        begin
          state_d = sleep_pkg::ST_WAKE;
        end
      end
      sleep_pkg::ST_WAKE:
      begin
        if (stall_at_end(stall_q))
        begin
          state_d = sleep_pkg::ST_ACTIVE;
        end
      end
    endcase
  end

  // State register; reset always returns to active from any state, so a reset
  // taken while asleep never resumes after the sleep instruction.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= sleep_pkg::ST_ACTIVE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Mode is captured on the sleep instruction only.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q <= sleep_pkg::MODE_IDLE;
    end
    else if (sleep_taken(state_q, sleep_exec, sleep_enable))
    begin
      mode_q <= sleep_mode;
    end
  end

  // Stall counter runs through the wake state and rests at zero elsewhere, so
  // every wake starts its count afresh.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stall_q <= sleep_pkg::STALL_ZERO;
    end
    else if (state_q == sleep_pkg::ST_WAKE)
    begin
      stall_q <= stall_q + sleep_pkg::STALL_ONE;
    end
    else
    begin
      stall_q <= sleep_pkg::STALL_ZERO;
    end
  end

  // One-cycle pulse when the core leaves the stall.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wake_pulse <= 1'b0;
    end
    else
    begin
      wake_pulse <= (state_q == sleep_pkg::ST_WAKE) && stall_at_end(stall_q);
    end
  end

  // Next-state decodes shared by the clock-enable registers; the enables are
  // registered from the next state so that they switch together with the state.
  always_comb
  begin
    sleep_next = (state_d == sleep_pkg::ST_SLEEP);
    deep_next = sleep_next && (mode_q != sleep_pkg::MODE_IDLE);
  end

  // Core clock: stopped from the accepted instruction until the stall ends, and
  // nothing is reset on wake, so register file and memory keep their contents.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      core_run <= 1'b1;
    end
    else
    begin
      core_run <= (state_d == sleep_pkg::ST_ACTIVE);
    end
  end

  // Flash clock: held while the controller drains a programming operation,
  // stopped only once the sleep state is reached.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nvm_clk_en <= 1'b1;
    end
    else
    begin
      nvm_clk_en <= !sleep_next;
    end
  end

  // Sleep status for the rest of the chip; high only in the sleep state.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      asleep <= 1'b0;
    end
    else
    begin
      asleep <= sleep_next;
    end
  end

  // Peripheral bus clock: kept in idle so that interrupt handling, event routing
  // and memory transfers go on; stopped in the deep modes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periph_bus_clk_en <= 1'b1;
    end
    else
    begin
      periph_bus_clk_en <= !deep_next;
    end
  end

  // Per-peripheral clocks: software gates apply in active and idle; a gated
  // peripheral simply gets no edges, so its state stays frozen.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      periph_clk_en <= '1;
    end
    else if (deep_next)
    begin
      periph_clk_en <= '0;
    end
    else
    begin
      periph_clk_en <= ~periph_gate;
    end
  end

  // Real-time counter clock: runs in active and idle, chosen per mode when deep.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rtc_clk_en <= 1'b1;
    end
    else if (deep_next)
    begin
      rtc_clk_en <= rtc_run_of(mode_q);
    end
    else
    begin
      rtc_clk_en <= 1'b1;
    end
  end

  // Wake mask of the latched mode, as seen by the interrupt controller.
  always_comb
  begin
    wake_sources = wake_mask;
  end

  // Handlers may dispatch only after the stall ends; the interrupt controller
  // takes them in priority order, the wake source last if it ranks lowest.
  always_comb
  begin
    irq_dispatch_en = (state_q == sleep_pkg::ST_ACTIVE);
  end

endmodule

`default_nettype wire

// ---- dv/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: one sleep instruction per request, only while running.
module core_model
(
  // Clock, request and instruction pulse.
  input wire logic clk,
  input wire logic go,
  input wire logic core_run,
  output logic sleep_exec
);
  initial sleep_exec = 1'b0;
  // A halted core executes nothing.
  always @(posedge clk)
    sleep_exec <= go && core_run;
endmodule
`default_nettype wire

// ---- dv/sleep_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches entry, wake stall and clock gating.
module sleep_monitor
(
  // Control and status.
  input wire logic clk, rst, sleep_enable, sleep_exec, core_run, wake_pulse, asleep,
  input wire sleep_pkg::sleep_mode_t sleep_mode,
  // Interrupts and enables.
  input wire logic [7:0] irq_pending, irq_enabled, wake_sources, periph_gate, periph_clk_en,
  input wire logic irq_dispatch_en, nvm_busy, nvm_clk_en, periph_bus_clk_en, rtc_clk_en
);
  sleep_pkg::sleep_mode_t mode_q;
  logic [7:0] hit;
  // Mode taken at entry, and live wake requests.
  assign hit = irq_pending & irq_enabled & wake_sources;
  always_ff @(posedge clk)
    if (sleep_exec && sleep_enable && core_run)
      mode_q <= sleep_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_enter; sleep_exec && sleep_enable && core_run |=> !core_run; endproperty
  a_enter: assert property (p_enter) else $error("no entry");
  property p_stall; asleep && hit != 8'h00 |=> !core_run [*4] ##1 core_run && wake_pulse;
  endproperty
  a_stall: assert property (p_stall) else $error("bad stall");
  property p_pd; asleep && mode_q == sleep_pkg::MODE_POWER_DOWN |-> wake_sources == 8'h07
    && !rtc_clk_en && periph_clk_en == 8'h00 && !periph_bus_clk_en; endproperty
  a_pd: assert property (p_pd) else $error("bad deep");
  property p_idle; asleep && mode_q == sleep_pkg::MODE_IDLE |-> wake_sources == 8'hff
    && periph_clk_en == ~$past(periph_gate) && !nvm_clk_en; endproperty
  a_idle: assert property (p_idle) else $error("bad idle");
  property p_nvm; !asleep && nvm_busy |=> !asleep; endproperty
  a_nvm: assert property (p_nvm) else $error("early sleep");
  property p_disp; !core_run |-> !irq_dispatch_en; endproperty
  a_disp: assert property (p_disp) else $error("early dispatch");
  property p_rst; $fell(rst) |-> core_run && !asleep && !wake_pulse; endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_gate; core_run && !$past(rst) |-> periph_clk_en == ~$past(periph_gate);
  endproperty
  a_gate: assert property (p_gate) else $error("bad gating");
endmodule
bind sleep_mode_controller sleep_monitor sleep_monitor_i (
  .clk(clk), .rst(rst), .sleep_enable(sleep_enable), .sleep_exec(sleep_exec),
  .core_run(core_run), .wake_pulse(wake_pulse), .asleep(asleep), .sleep_mode(sleep_mode),
  .irq_pending(irq_pending), .irq_enabled(irq_enabled), .wake_sources(wake_sources),
  .periph_gate(periph_gate), .periph_clk_en(periph_clk_en),
  .irq_dispatch_en(irq_dispatch_en), .nvm_busy(nvm_busy), .nvm_clk_en(nvm_clk_en),
  .periph_bus_clk_en(periph_bus_clk_en), .rtc_clk_en(rtc_clk_en)
);
`default_nettype wire

// ---- dv/test_sleep_mode_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_controller;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, sleep_enable = 1'b1, nvm_busy = 1'b0;
  sleep_pkg::sleep_mode_t sleep_mode = sleep_pkg::MODE_IDLE;
  logic [7:0] irq_pending = 8'h00, irq_enabled = 8'hff, periph_gate = 8'h5a;
  logic sleep_exec, core_run, wake_pulse, irq_dispatch_en, nvm_clk_en, periph_bus_clk_en;
  logic rtc_clk_en, asleep;
  logic [7:0] wake_sources, periph_clk_en;
  logic [7:0] mask [5] = '{8'hff, 8'h07, 8'h0f, 8'h0f, 8'h0f};
  int failures = 0, n_checks = 0, cycles = 0;
  sleep_mode_controller sleep_mode_controller_i (
    .clk(clk), .rst(rst), .sleep_enable(sleep_enable), .sleep_mode(sleep_mode),
    .sleep_exec(sleep_exec), .core_run(core_run), .wake_pulse(wake_pulse),
    .irq_pending(irq_pending), .irq_enabled(irq_enabled), .wake_sources(wake_sources),
    .irq_dispatch_en(irq_dispatch_en), .nvm_busy(nvm_busy), .nvm_clk_en(nvm_clk_en),
    .periph_gate(periph_gate), .periph_clk_en(periph_clk_en),
    .periph_bus_clk_en(periph_bus_clk_en), .rtc_clk_en(rtc_clk_en), .asleep(asleep)
  );
  core_model core_model_i (
    .clk(clk), .go(go), .core_run(core_run), .sleep_exec(sleep_exec)
  );
  // Clock and hang guard.
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      failures++;
      complete_run;
    end
  end
  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic enter(input sleep_pkg::sleep_mode_t m);
    @(posedge clk) sleep_mode <= m;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // Raise a wake line and time the stall.
  task automatic wake(input logic [7:0] v);
    @(posedge clk) irq_pending <= v;
    repeat (5)
    begin
      @(negedge clk) chk(core_run, 1'b0);
      chk(irq_dispatch_en, 1'b0);
    end
    @(negedge clk) chk(core_run, 1'b1);
    chk(wake_pulse, 1'b1);
    chk(irq_dispatch_en, 1'b1);
    chk(periph_clk_en, ~periph_gate);
    chk(asleep, 1'b0);
    @(posedge clk) irq_pending <= 8'h00;
    @(negedge clk) chk(wake_pulse, 1'b0);
  endtask
  // Software gates in active mode; ungated branches keep their clocks.
  task automatic t_gate;
    @(posedge clk) periph_gate <= 8'h3c;
    repeat (2) @(negedge clk);
    chk(periph_clk_en, 8'hc3);
    chk(core_run, 1'b1);
    @(posedge clk) periph_gate <= 8'h5a;
  endtask
  // Every mode: wake set and clocks; a refused wake line in the four deep modes.
  task automatic t_modes;
    for (int m = 0; m < 5; m++)
    begin
      enter(sleep_pkg::sleep_mode_t'(m));
      chk(asleep, 1'b1);
      chk(wake_sources, mask[m]);
      chk(rtc_clk_en, m % 2 == 0);
      chk(periph_clk_en, m == 0 ? ~periph_gate : 8'h00);
      chk(nvm_clk_en, 1'b0);
      chk(periph_bus_clk_en, m == 0);
      if (m != 0)
      begin
        @(posedge clk) irq_pending <= 8'h80;
        repeat (3) @(negedge clk);
        chk(asleep, 1'b1);
      end
      wake(m == 0 ? 8'h80 : 8'h04);
    end
  endtask
  // Programming delays sleep; disabled sleep and reset in sleep.
  task automatic t_misc;
    @(posedge clk) nvm_busy <= 1'b1;
    enter(sleep_pkg::MODE_IDLE);
    chk(core_run, 1'b0);
    chk(asleep, 1'b0);
    chk(nvm_clk_en, 1'b1);
    @(posedge clk) nvm_busy <= 1'b0;
    repeat (3) @(negedge clk);
    chk(asleep, 1'b1);
    wake(8'h01);
    @(posedge clk) sleep_enable <= 1'b0;
    enter(sleep_pkg::MODE_POWER_DOWN);
    chk(core_run, 1'b1);
    chk(asleep, 1'b0);
    @(posedge clk) sleep_enable <= 1'b1;
    enter(sleep_pkg::MODE_POWER_DOWN);
    chk(asleep, 1'b1);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    @(negedge clk) chk(core_run, 1'b1);
    chk(asleep, 1'b0);
  endtask
  // Reset, then the scenarios.
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_modes;
    t_gate;
    t_misc;
    complete_run;
  end
endmodule
`default_nettype wire
